/* File: core/pra_regs.sv */
// rtc alarm, day and regulator setting register bank
//
// Overview of operation
// R1: rtc words reset only on backup power-on reset, kept through global reset.
// R2: time alarm field bits 0..16, read/write, all ones after power-on.
// R3: clock disable bit 23 of alarm word, default zero, stops the rtc.
// R4: day counter bits 0..14, read/write, zero after power-on reset.
// R5: day alarm bits 0..14, read/write, all ones after power-on reset.
// R6: buck one normal and standby voltage fields, untouched by every soft reset.
// R7: buck three normal bits 12..16, standby bits 18..22, shared word.
// R8: buck 4b normal 12..16, standby 17..21, high 22..23; 16..23 system reset.
// R9: start-up reload sets mode fields; otherwise system reset gives 0101.
// R10: buck enabled by start-up sequence gets auto pulse skip mode.
// R11: memory hold and user off bits default zero, cleared by off reset.
// R12: pll enable bit 22 default one, multiplier bit 23 default zero.
// R13: scaling speed fields buck one 6..7, buck two 20..21, default 01.
// R14: linear regulator voltage fields in one word, all system reset.
// R15: unused bits read zero and ignore writes.
// R16: each register is one 24-bit word read or written in one access.
`timescale 1ns/1ps
module pra_regs #(
	// mode code for an enabled buck; value is arbitrary
	parameter logic [3:0] MODE_AUTO_PULSE_SKIP = 4'h8
) (
	// clock and backup power on reset
	input  wire logic                core_clk,
	input  wire logic                rst,
	// soft resets from the power sequencer, one cycle pulses
	input  wire logic                system_reset,
	input  wire logic                off_state_reset,
	input  wire logic                global_system_reset,
	// start-up sequencer reload
	input  wire logic                startup_load,
	input  wire logic [5:0]          buck_start_en,
	// serial control interface, word level
	input  wire pra_pkg::pra_req_t   host_req,
	output pra_pkg::pra_rsp_t        host_rsp,
	// register contents toward the analog
	output logic [9:0][23:0]         reg_word,
	output logic                     clock_disable_bit,
	output logic                     pll_enable_bit,
	output logic                     pll_multiplier_bit
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic [5:0]  word_idx;
	logic        hit;
	logic [9:0]  wr_sel;
	logic [23:0] ld_val7;
	logic [23:0] ld_val8;
	logic [23:0] ld_msk7;
	logic [23:0] ld_msk8;

	// word index from offset; out-of-map addresses hit nothing
	assign word_idx = host_req.addr - pra_pkg::PRA_OFS_BASE;
	assign hit      = (host_req.addr >= pra_pkg::PRA_OFS_BASE) &&
	                  (word_idx < 6'(pra_pkg::PRA_NREG));

	// ------------------------------------------------------------
	// start-up mode reload values
	// ------------------------------------------------------------
	// each buck mode field gets skip mode when enabled, default when not
	always_comb begin
		ld_val7 = 24'h000000;
		ld_val8 = 24'h000000;
		ld_msk7 = 24'h000000;
		ld_msk8 = 24'h000000;
		for (int b = 0; b < pra_pkg::PRA_NBUCK; b++) begin
			// R9 mode reload
			// R10 auto pulse skip
			if (pra_pkg::PRA_MODE_WORD[b] == pra_pkg::PRA_IDX_MODE12) begin
				ld_msk7[pra_pkg::PRA_MODE_LSB[b] +: pra_pkg::PRA_MW] = 4'hF;
				ld_val7[pra_pkg::PRA_MODE_LSB[b] +: pra_pkg::PRA_MW] =
					buck_start_en[b] ? MODE_AUTO_PULSE_SKIP
					                 : pra_pkg::PRA_MODE_DEFAULT;
			end else begin
				ld_msk8[pra_pkg::PRA_MODE_LSB[b] +: pra_pkg::PRA_MW] = 4'hF;
				ld_val8[pra_pkg::PRA_MODE_LSB[b] +: pra_pkg::PRA_MW] =
					buck_start_en[b] ? MODE_AUTO_PULSE_SKIP
					                 : pra_pkg::PRA_MODE_DEFAULT;
			end
		end
	end

	// ------------------------------------------------------------
	// register words
	// ------------------------------------------------------------
	// global reset is not wired to any word: rtc and all other fields survive it
	genvar g;
	generate
		for (g = 0; g < pra_pkg::PRA_NREG; g++) begin : g_word
			// R16 whole word write
			assign wr_sel[g] = host_req.wr && hit &&
			                   (word_idx == 6'(g));
			// R1 R2 R3 R4 R5 R6 R7 R8 R11 R12 R13 R14 R15 reset domains
			pra_word #(
				.WMASK (pra_pkg::PRA_WMASK[g]),
				.POR   (pra_pkg::PRA_POR[g]),
				.SYSM  (pra_pkg::PRA_SYSM[g]),
				.SYSV  (pra_pkg::PRA_SYSV[g]),
				.OFFM  (pra_pkg::PRA_OFFM[g])
			) u_word (
				.core_clk (core_clk),
				.rst      (rst),
				.sys_rst  (system_reset),
				.off_rst  (off_state_reset),
				.wr_en    (wr_sel[g]),
				.wdata    (host_req.wdata),
				.ld_en    (startup_load &&
				           ((g == pra_pkg::PRA_IDX_MODE12) ||
				            (g == pra_pkg::PRA_IDX_MODE345))),
				.ld_mask  ((g == pra_pkg::PRA_IDX_MODE12) ? ld_msk7
				                                           : ld_msk8),
				.ld_val   ((g == pra_pkg::PRA_IDX_MODE12) ? ld_val7
				                                           : ld_val8),
				.word     (reg_word[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// control bits toward the rtc and pll
	// ------------------------------------------------------------
	// R3 rtc disable
	assign clock_disable_bit  = reg_word[pra_pkg::PRA_IDX_ALARM]
	                                    [pra_pkg::PRA_BIT_CLOCK_DISABLE];
	// R12 pll controls
	assign pll_enable_bit     = reg_word[pra_pkg::PRA_IDX_MODE12]
	                                    [pra_pkg::PRA_BIT_PLL_ENABLE];
	assign pll_multiplier_bit = reg_word[pra_pkg::PRA_IDX_MODE12]
	                                    [pra_pkg::PRA_BIT_PLL_MULT];

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// registered so the answer comes from a flop; unmapped reads zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			host_rsp <= '0;
		end else begin
			host_rsp.valid <= host_req.rd;
			// R15 unmapped zero
			// R16 whole word read
			if (host_req.rd && hit) begin
				host_rsp.data <= reg_word[word_idx[3:0]];
			end else if (host_req.rd) begin
				host_rsp.data <= 24'h000000;
			end
		end
	end

endmodule

/* File: core/pra_pkg.sv */
// constants, register map and carrier types of the rtc alarm and regulator bank
package pra_pkg;

	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int          PRA_DW    = 24;
	localparam int          PRA_AW    = 6;
	localparam int          PRA_NREG  = 10;
	localparam int          PRA_NBUCK = 6;
	localparam int          PRA_MW    = 4;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [5:0] PRA_OFS_RTC_TIME_ALARM     = 6'h15;
	localparam logic [5:0] PRA_OFS_RTC_DAY_COUNT      = 6'h16;
	localparam logic [5:0] PRA_OFS_RTC_DAY_ALARM      = 6'h17;
	localparam logic [5:0] PRA_OFS_BUCK_ONE_VOLTAGE   = 6'h18;
	localparam logic [5:0] PRA_OFS_BUCK_TWO_THREE_V   = 6'h19;
	localparam logic [5:0] PRA_OFS_BUCK_FOUR_VOLTAGE  = 6'h1A;
	localparam logic [5:0] PRA_OFS_BUCK_FIVE_VOLTAGE  = 6'h1B;
	localparam logic [5:0] PRA_OFS_BUCK_ONE_TWO_MODE  = 6'h1C;
	localparam logic [5:0] PRA_OFS_BUCK_THREE_TO_FIVE = 6'h1D;
	localparam logic [5:0] PRA_OFS_LINEAR_REG_VOLTAGE = 6'h1E;
	// first offset; word index = offset - base
	localparam logic [5:0] PRA_OFS_BASE = PRA_OFS_RTC_TIME_ALARM;

	// word indices used by the top
	localparam int PRA_IDX_ALARM = 0;
	localparam int PRA_IDX_MODE12 = 7;
	localparam int PRA_IDX_MODE345 = 8;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PRA_BIT_CLOCK_DISABLE = 23;
	localparam int PRA_BIT_PLL_ENABLE    = 22;
	localparam int PRA_BIT_PLL_MULT      = 23;
	// mode field lsb per buck: 1, 2 (word 7); 3, 4a, 4b, 5 (word 8)
	localparam int PRA_MODE_LSB [PRA_NBUCK] = '{0, 14, 0, 6, 12, 18};
	localparam int PRA_MODE_WORD [PRA_NBUCK] = '{7, 7, 8, 8, 8, 8};

	// ------------------------------------------------------------
	// mode codes
	// ------------------------------------------------------------
	localparam logic [3:0] PRA_MODE_DEFAULT = 4'h5;

	// ------------------------------------------------------------
	// per word masks and reset values, index 9 down to 0
	// ------------------------------------------------------------
	// writable (and readable) bits; all others read zero
	localparam logic [9:0][23:0] PRA_WMASK = {
		24'h001FF7, 24'hFFFFFF, 24'hFFC0FF, 24'h007C1F, 24'hFFFFFF,
		24'h7DFFFF, 24'h000FFF, 24'h007FFF, 24'h007FFF, 24'h81FFFF};
	// value taken under the backup power on reset
	localparam logic [9:0][23:0] PRA_POR = {
		24'h000000, 24'h145145, 24'h514045, 24'h000000, 24'h000000,
		24'h000000, 24'h000000, 24'h007FFF, 24'h000000, 24'h01FFFF};
	// bits restored by the system reset, and their values
	localparam logic [9:0][23:0] PRA_SYSM = {
		24'h001FF7, 24'h3CF3CF, 24'hF3C0CF, 24'h000000, 24'hFF0000,
		24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000};
	localparam logic [9:0][23:0] PRA_SYSV = {
		24'h000000, 24'h145145, 24'h514045, 24'h000000, 24'h000000,
		24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000};
	// memory hold and user off bits cleared by the off state reset
	localparam logic [9:0][23:0] PRA_OFFM = {
		24'h000000, 24'hC30C30, 24'h0C0030, 24'h000000, 24'h000000,
		24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000};

	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [5:0]        addr;
		logic [23:0]       wdata;
	} pra_req_t;

	typedef struct packed {
		logic              valid;
		logic [23:0]       data;
	} pra_rsp_t;

endpackage

/* File: core/pra_word.sv */
// one 24 bit register word with per bit reset domains
`timescale 1ns/1ps
module pra_word #(
	parameter logic [23:0] WMASK = 24'h000000,
	parameter logic [23:0] POR   = 24'h000000,
	parameter logic [23:0] SYSM  = 24'h000000,
	parameter logic [23:0] SYSV  = 24'h000000,
	parameter logic [23:0] OFFM  = 24'h000000
) (
	// clock and resets
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        sys_rst,
	input  wire logic        off_rst,
	// host write
	input  wire logic        wr_en,
	input  wire logic [23:0] wdata,
	// start-up reload
	input  wire logic        ld_en,
	input  wire logic [23:0] ld_mask,
	input  wire logic [23:0] ld_val,
	// stored word
	output logic      [23:0] word
);

	logic [23:0] next_word;

	// merge write, reload and the two soft resets; resets win last
	always_comb begin
		next_word = word;
		if (wr_en) begin
			next_word = (next_word & ~WMASK) | (wdata & WMASK);
		end
		if (ld_en) begin
			next_word = (next_word & ~ld_mask) | (ld_val & ld_mask);
		end
		if (off_rst) begin
			next_word = next_word & ~OFFM;
		end
		if (sys_rst) begin
			next_word = (next_word & ~SYSM) | (SYSV & SYSM);
		end
	end

	// masking here keeps unused bits at zero whatever is written
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			word <= POR & WMASK;
		end else begin
			word <= next_word & WMASK;
		end
	end

endmodule

/* File: test/pra_host.sv */
// host model issuing whole word accesses to the bank
`timescale 1ns/1ps
module pra_host (
	// clock
	input  wire logic         core_clk,
	// request toward the bank
	output pra_pkg::pra_req_t host_req
);
	initial host_req = '0;
	task automatic access(input logic w, input logic [5:0] a,
		input logic [23:0] d);
		@(negedge core_clk);
		host_req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge core_clk);
		// released lines carry garbage, never the old value
		host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule

/* File: test/pra_regs_monitor.sv */
// assertion checker for the rtc alarm and regulator bank
`timescale 1ns/1ps
module pra_regs_monitor (
	// clock and resets
	input wire logic              core_clk,
	input wire logic              rst,
	input wire logic              system_reset,
	input wire logic              off_state_reset,
	input wire logic              global_system_reset,
	// host side and contents
	input wire pra_pkg::pra_req_t host_req,
	input wire pra_pkg::pra_rsp_t host_rsp,
	input wire logic [9:0][23:0]  reg_word,
	input wire logic              clock_disable_bit,
	input wire logic              pll_enable_bit
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [23:0] old_word;
	// word addressed by a read, as it stood before the read edge
	always_ff @(posedge core_clk)
		old_word <= reg_word[host_req.addr - 6'h15];
	sequence s_rd_hit;
		host_req.rd && host_req.addr inside {[6'h15:6'h1E]};
	endsequence
	a_read_answer: assert property (host_req.rd |=> host_rsp.valid)
		else $error("read not answered");
	a_no_stray: assert property (!host_req.rd |=> !host_rsp.valid)
		else $error("answer without read");
	a_read_data: assert property (s_rd_hit |=> host_rsp.data == old_word)
		else $error("read data wrong");
	a_unmapped_zero: assert property (host_req.rd && !(host_req.addr inside
		{[6'h15:6'h1E]}) |=> host_rsp.data == 24'h000000)
		else $error("unmapped read not zero");
	a_unused_zero: assert property ((reg_word & ~pra_pkg::PRA_WMASK) == '0)
		else $error("unused bit set");
	a_disable_tie: assert property (host_req.wr && host_req.addr == 6'h15
		|=> clock_disable_bit == $past(host_req.wdata[23]))
		else $error("clock disable output wrong");
	a_sys_defaults: assert property (system_reset |=> reg_word[7][3:0] ==
		4'h5 && reg_word[8][3:0] == 4'h5 && pll_enable_bit)
		else $error("system reset defaults wrong");
	a_off_clear: assert property (off_state_reset |=>
		(reg_word[7] & 24'h0C0030) == 0 && (reg_word[8] & 24'hC30C30) == 0)
		else $error("off reset left hold bits");
	a_global_keep: assert property (global_system_reset && !host_req.wr
		|=> $stable(reg_word[2:0]))
		else $error("global reset touched rtc words");
endmodule
bind pra_regs pra_regs_monitor mon (.core_clk(core_clk), .rst(rst),
	.system_reset(system_reset), .off_state_reset(off_state_reset),
	.global_system_reset(global_system_reset), .host_req(host_req),
	.host_rsp(host_rsp), .reg_word(reg_word),
	.clock_disable_bit(clock_disable_bit), .pll_enable_bit(pll_enable_bit));

/* File: test/pra_regs_tb.sv */
// self-checking bench for the rtc alarm and regulator bank
`timescale 1ns/1ps
module pra_regs_tb;
	localparam logic [3:0] APS = 4'hA;
	// writable bits and power-on values per word
	localparam logic [23:0] WM [10] = '{24'h81FFFF, 24'h007FFF, 24'h007FFF,
		24'h000FFF, 24'h7DFFFF, 24'hFFFFFF, 24'h007C1F, 24'hFFC0FF,
		24'hFFFFFF, 24'h001FF7};
	localparam logic [23:0] PV [10] = '{24'h01FFFF, 24'h0, 24'h007FFF,
		24'h0, 24'h0, 24'h0, 24'h0, 24'h514045, 24'h145145, 24'h0};
	localparam int BW [6] = '{7, 7, 8, 8, 8, 8};
	localparam int BL [6] = '{0, 14, 0, 6, 12, 18};
	logic              core_clk = 1'b0;
	logic              rst = 1'b1;
	logic              system_reset = 1'b0;
	logic              off_state_reset = 1'b0;
	logic              global_system_reset = 1'b0;
	logic              startup_load = 1'b0;
	logic [5:0]        buck_start_en = 6'h00;
	pra_pkg::pra_req_t host_req;
	pra_pkg::pra_rsp_t host_rsp;
	logic [9:0][23:0]  reg_word;
	logic              clk_dis;
	logic              pll_en;
	logic              pll_mul;
	logic [23:0]       mdl [10];
	logic [23:0]       exp_q [$];
	logic [31:0]       seed = 32'h23FA;
	int                error_cnt = 0;
	int                check_count = 0;
	always #25 core_clk = ~core_clk;
	pra_host host (.core_clk(core_clk), .host_req(host_req));
	pra_regs #(.MODE_AUTO_PULSE_SKIP(APS)) dut (.core_clk(core_clk),
		.rst(rst), .system_reset(system_reset),
		.off_state_reset(off_state_reset),
		.global_system_reset(global_system_reset),
		.startup_load(startup_load), .buck_start_en(buck_start_en),
		.host_req(host_req), .host_rsp(host_rsp), .reg_word(reg_word),
		.clock_disable_bit(clk_dis), .pll_enable_bit(pll_en),
		.pll_multiplier_bit(pll_mul));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input string nm, input logic [23:0] s, e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		if (a inside {[6'h15:6'h1E]})
			mdl[a - 6'h15] = d & WM[a - 6'h15];
		host.access(1'b1, a, d);
	endtask
	task automatic rd(input logic [5:0] a, input logic [23:0] e);
		exp_q.push_back(e);
		host.access(1'b0, a, 24'h000000);
	endtask
	// read every word, then wait a bounded time for the answers
	task automatic check_all;
		for (int i = 0; i < 10; i++)
			rd(6'h15 + 6'(i), mdl[i]);
		for (int k = 0; k < 4 && exp_q.size() > 0; k++)
			@(negedge core_clk);
		if (exp_q.size() > 0) begin
			error_cnt++;
			wrap_up();
		end
		// control outputs must follow the stored words
		check("clock disable", 24'(clk_dis), 24'(mdl[0][23]));
		check("pll enable", 24'(pll_en), 24'(mdl[7][22]));
		check("pll multiplier", 24'(pll_mul), 24'(mdl[7][23]));
	endtask
	task automatic pulse(ref logic s);
		@(negedge core_clk) s = 1'b1;
		@(negedge core_clk) s = 1'b0;
	endtask
	// answers come back in order and are settled at mid-cycle
	always @(negedge core_clk)
		if (host_rsp.valid === 1'b1)
			check("read data", host_rsp.data,
				exp_q.size() > 0 ? exp_q.pop_front() : ~host_rsp.data);
	initial begin
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		mdl = PV;
		check_all();
		rd(6'h20, 24'h000000);
		$display("test reset values done");
		for (int r = 0; r < 3; r++) begin
			for (int i = 0; i < 10; i++) begin
				seed = xs(seed);
				wr(6'h15 + 6'(i), seed[23:0]);
			end
			wr(6'h3F, ~seed[23:0]);
			check_all();
			pulse(global_system_reset);
			check_all();
			pulse(off_state_reset);
			mdl[7] &= ~24'h0C0030;
			mdl[8] &= ~24'hC30C30;
			check_all();
			buck_start_en = seed[29:24];
			pulse(startup_load);
			for (int b = 0; b < 6; b++)
				mdl[BW[b]][BL[b] +: 4] = buck_start_en[b] ? APS : 4'h5;
			check_all();
			pulse(system_reset);
			mdl[5][23:16] = 8'h00;
			mdl[7] = mdl[7] & ~24'hF3C0CF | 24'h514045;
			mdl[8] = mdl[8] & ~24'h3CF3CF | 24'h145145;
			mdl[9] = 24'h000000;
			check_all();
		end
		$display("test writes and resets done");
		rst = 1'b1;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		mdl = PV;
		check_all();
		$display("test second power-on done");
		wrap_up();
	end
endmodule
